// [core/cxio_core.sv]
// Execution sequencer and register set for one slice of the instruction set.
//
// Function
// - Increment adds one to accumulator or memory; V only when operand 7F.
// - Stack pointer increment adds one, flags untouched, four cycles.
// - Index increment adds one, only Z changes over 16 bits.
// - Jump loads PC with extended or indexed address, flags untouched.
// - Call forms return address PC+3 extended or PC+2 indexed first.
// - Call pushes low then high return byte, decrementing stack each time.
// - Call takes nine cycles extended, eight cycles indexed.
// - Accumulator load copies operand, sets N and Z, clears V.
// - Accumulator load takes 2, 3, 4, 5 cycles by mode.
// - Stack load fills high then low byte, N and Z over 16 bits.
// - Stack and index loads take 3, 4, 5, 6 cycles by mode.
// - Index load fills high then low byte, N and Z over 16 bits.
// - Shift right moves bits toward bit 0, zero into bit 7, C old bit 0.
// - Shift right sets V to N xor C; 2, 6 or 7 cycles.
// - Negate gives zero minus operand; 80 stays and alone sets V.
// - Negate sets C unless operand was 00; H untouched.
// - No-operation only advances PC, two cycles.
// - Inclusive OR into accumulator, N and Z updated, V cleared.
`timescale 1ns/10ps
module cxio_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Memory bus
   input wire logic [7:0] memRdata,
   output cxio_pkg::cxio_bus_t busOut,
   // Architectural state
   output cxio_pkg::cxio_regs_t regsOut,
   output logic fetchStrobe
);
   import cxio_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_FETCH = 6'b000001,
      ST_OPND = 6'b000010,
      ST_MEMRD = 6'b000100,
      ST_EXEC = 6'b001000,
      ST_WAIT = 6'b010000,
      ST_PUSH = 6'b100000
   } cxio_state_t;

   cxio_state_t state_q;
   cxio_regs_t r_q;
   cxio_bus_t bus_q;
   logic [7:0] op_q;
   logic [1:0] opndLeft_q;
   logic [1:0] memLeft_q;
   logic [3:0] wait_q;
   logic [15:0] ea_q;
   logic [15:0] ret_q;
   logic pushHigh_q;
   logic [7:0] mdat_q;
   logic strobe_q;
   logic [15:0] opWord;
   logic [7:0] aluRes;
   logic [7:0] aluCc;
   logic [7:0] aluAcc;
   cxio_alu_t aluOp;
   logic [15:0] wNow;
   logic [15:0] pcInc;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Total cycle count for an opcode, one fetch cycle included.
   function automatic logic [3:0] cyclesOf(input logic [7:0] op);
      logic [1:0] am;
      am = op[5:4];
      cyclesOf = 4'd2;
      if (op == OP_SPINC || op == OP_IXINC) cyclesOf = 4'd4;
      else if (op == OP_JMPE) cyclesOf = 4'd3;
      else if (op == OP_JMPI) cyclesOf = 4'd4;
      else if (op == OP_CALLE) cyclesOf = 4'd9;
      else if (op == OP_CALLI) cyclesOf = 4'd8;
      else if (op[7] && (op[3:0] == NIB_LDA || op[3:0] == NIB_ORA))
         cyclesOf = 4'd2 + {2'b00, am == AM_EXT ? 2'd2 : am == AM_IDX ? 2'd3 : am};
      else if (op[7] && op[3:0] == NIB_LDS)
         cyclesOf = 4'd3 + {2'b00, am == AM_EXT ? 2'd2 : am == AM_IDX ? 2'd3 : am};
      else if (op[7:4] == 4'h7) cyclesOf = 4'd6;
      else if (op[7:4] == 4'h6) cyclesOf = 4'd7;
   endfunction

   // Operand bytes following the opcode.
   function automatic logic [1:0] opndOf(input logic [7:0] op);
      opndOf = 2'd0;
      if (op[7] || op[7:4] == 4'h6 || op[7:4] == 4'h7) begin
         opndOf = (op[5:4] == AM_EXT) ? 2'd2 : 2'd1;
         if (op[7] && op[3:0] == NIB_LDS && op[5:4] == AM_IMM) opndOf = 2'd2;
      end
   endfunction

   // Memory data bytes read at the effective address.
   function automatic logic [1:0] memOf(input logic [7:0] op);
      memOf = 2'd0;
      if (op == OP_JMPE || op == OP_JMPI || op == OP_CALLE || op == OP_CALLI) memOf = 2'd0;
      else if (op[7] && op[5:4] != AM_IMM) memOf = (op[3:0] == NIB_LDS) ? 2'd2 : 2'd1;
      else if (op[7:4] == 4'h6 || op[7:4] == 4'h7) memOf = 2'd1;
   endfunction

   // Effective address from the collected operand.
   function automatic logic [15:0] eaOf(input logic [7:0] op, input logic [15:0] w,
                                        input logic [15:0] ix);
      unique case (op[5:4])
         AM_DIR: eaOf = {8'h00, w[7:0]};
         AM_IDX: eaOf = ix + {8'h00, w[7:0]};
         default: eaOf = w;
      endcase
   endfunction

   // Idle bus, or the next opcode fetch when one cycle of the length is left.
   function automatic cxio_bus_t endBus(input logic [3:0] left, input logic [15:0] a);
      endBus = '{addr: a, wdata: BYTE_ZERO, rd: (left == 4'd1), wr: 1'b0};
   endfunction

   // Fetch next when the length is used up, otherwise pad in the wait state.
   function automatic cxio_state_t endState(input logic [3:0] left);
      endState = (left == 4'd1) ? ST_FETCH : ST_WAIT;
   endfunction

   // Register set after a load or OR has taken its last byte.
   function automatic cxio_regs_t loadRegs(input cxio_regs_t r, input logic [7:0] op,
                                           input logic [15:0] w, input logic [7:0] res,
                                           input logic [7:0] cc, input logic [15:0] pc);
      loadRegs = r;
      loadRegs.pc = pc;
      if (op[3:0] == NIB_LDS) begin
         // High byte came first, so it sits in the upper half.
         loadRegs.cc[CC_N] = w[15];
         loadRegs.cc[CC_Z] = (w == 16'h0000);
         loadRegs.cc[CC_V] = 1'b0;
         if (op[6]) loadRegs.ix = w;
         else loadRegs.sp = w;
      end else begin
         loadRegs.cc = cc;
         if (op[6]) loadRegs.accB = res;
         else loadRegs.accA = res;
      end
   endfunction

   // ----------------------------------------------------------------
   // Operand collector and ALU
   // ----------------------------------------------------------------
   cxio_fetch u_fetch (
      .core_clk(core_clk),
      .rst(rst),
      .clear(state_q == ST_FETCH),
      .take((state_q == ST_OPND) || (state_q == ST_MEMRD)),
      .din(memRdata),
      .word(opWord)
   );

   // Operand word with the byte on the bus now, and the next program address.
   assign wNow = {opWord[7:0], memRdata};
   assign pcInc = r_q.pc + WORD_ONE;

   // Memory-form shifts operate on the fetched byte, register forms on the accumulator.
   always_comb begin
      aluAcc = op_q[6] ? r_q.accB : r_q.accA;
      if (op_q[7]) aluAcc = op_q[6] ? r_q.accB : r_q.accA;
      else if (op_q[5]) aluAcc = mdat_q;
      else aluAcc = op_q[4] ? r_q.accB : r_q.accA;
      if (op_q[7]) aluOp = (op_q[3:0] == NIB_ORA) ? ALU_OR : ALU_LD;
      else if (op_q[3:0] == OP_LSRA[3:0]) aluOp = ALU_LSR;
      else if (op_q[3:0] == OP_NEGA[3:0]) aluOp = ALU_NEG;
      else aluOp = ALU_INC;
   end

   cxio_alu u_alu (
      .op(aluOp),
      .acc(aluAcc),
      .mem(memRdata),
      .ccIn(r_q.cc),
      .res(aluRes),
      .ccOut(aluCc)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Six-flop one-hot state plus cycle padding; memory is assumed to answer in one cycle.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_FETCH;
         op_q <= OP_NOOP;
         opndLeft_q <= 2'd0;
         memLeft_q <= 2'd0;
         wait_q <= 4'd0;
         ea_q <= RESET_PC;
         ret_q <= RESET_PC;
         pushHigh_q <= 1'b0;
         mdat_q <= BYTE_ZERO;
         strobe_q <= 1'b0;
         r_q <= '{accA: BYTE_ZERO, accB: BYTE_ZERO, ix: 16'h0000, sp: RESET_SP,
                  pc: RESET_PC, cc: CC_RESET};
         bus_q <= '{addr: RESET_PC, wdata: BYTE_ZERO, rd: 1'b1, wr: 1'b0};
      end else begin
         strobe_q <= 1'b0;
         // Work ends on the edge that takes its last byte, so the short forms keep their length.
         if (wait_q != 4'd0) wait_q <= wait_q - 4'd1;
         unique case (state_q)
            ST_FETCH: begin
               op_q <= memRdata;
               strobe_q <= 1'b1;
               r_q.pc <= pcInc;
               wait_q <= cyclesOf(memRdata) - 4'd1;
               opndLeft_q <= opndOf(memRdata);
               memLeft_q <= memOf(memRdata);
               bus_q.addr <= pcInc;
               bus_q.rd <= (opndOf(memRdata) != 2'd0);
               if (opndOf(memRdata) != 2'd0) state_q <= ST_OPND;
               else state_q <= ST_EXEC;
            end
            ST_OPND: begin
               r_q.pc <= pcInc;
               opndLeft_q <= opndLeft_q - 2'd1;
               bus_q.addr <= pcInc;
               if (opndLeft_q == 2'd1) begin
                  ea_q <= eaOf(op_q, wNow, r_q.ix);
                  if (op_q == OP_JMPE || op_q == OP_JMPI) begin
                     r_q.pc <= eaOf(op_q, wNow, r_q.ix);
                     bus_q <= endBus(wait_q, eaOf(op_q, wNow, r_q.ix));
                     state_q <= endState(wait_q);
                  end else if (op_q == OP_CALLE || op_q == OP_CALLI) begin
                     // PC now points past the instruction, so this is start + 3 or + 2.
                     ret_q <= pcInc;
                     bus_q <= '{addr: r_q.sp, wdata: pcInc[7:0], rd: 1'b0, wr: 1'b1};
                     pushHigh_q <= 1'b0;
                     state_q <= ST_PUSH;
                  end else if (memLeft_q != 2'd0) begin
                     bus_q.addr <= eaOf(op_q, wNow, r_q.ix);
                     state_q <= ST_MEMRD;
                  end else begin
                     r_q <= loadRegs(r_q, op_q, wNow, aluRes, aluCc, pcInc);
                     bus_q <= endBus(wait_q, pcInc);
                     state_q <= endState(wait_q);
                  end
               end
            end
            ST_MEMRD: begin
               mdat_q <= memRdata;
               memLeft_q <= memLeft_q - 2'd1;
               bus_q.addr <= bus_q.addr + WORD_ONE;
               if (memLeft_q == 2'd1) begin
                  if (op_q[7]) begin
                     r_q <= loadRegs(r_q, op_q, wNow, aluRes, aluCc, r_q.pc);
                     bus_q <= endBus(wait_q, r_q.pc);
                     state_q <= endState(wait_q);
                  end else begin
                     bus_q.rd <= 1'b0;
                     state_q <= ST_EXEC;
                  end
               end
            end
            ST_EXEC: begin
               bus_q <= endBus(wait_q, r_q.pc);
               state_q <= endState(wait_q);
               if (op_q == OP_SPINC) r_q.sp <= r_q.sp + WORD_ONE;
               else if (op_q == OP_IXINC) begin
                  r_q.ix <= r_q.ix + WORD_ONE;
                  r_q.cc[CC_Z] <= ((r_q.ix + WORD_ONE) == 16'h0000);
               end else if (op_q == OP_NOOP) begin
                  r_q.pc <= r_q.pc;
               end else begin
                  r_q.cc <= aluCc;
                  if (op_q[5]) begin
                     // Memory forms write back with one strobe; they always have slack left.
                     bus_q <= '{addr: ea_q, wdata: aluRes, rd: 1'b0, wr: 1'b1};
                     state_q <= ST_WAIT;
                  end else if (op_q[4]) r_q.accB <= aluRes;
                  else r_q.accA <= aluRes;
               end
            end
            ST_PUSH: begin
               r_q.sp <= r_q.sp - WORD_ONE;
               if (!pushHigh_q) begin
                  bus_q <= '{addr: r_q.sp - WORD_ONE, wdata: ret_q[15:8], rd: 1'b0, wr: 1'b1};
                  pushHigh_q <= 1'b1;
               end else begin
                  r_q.pc <= ea_q;
                  bus_q <= endBus(wait_q, ea_q);
                  state_q <= endState(wait_q);
               end
            end
            ST_WAIT: begin
               bus_q <= endBus(wait_q, r_q.pc);
               state_q <= endState(wait_q);
            end
            default: state_q <= ST_FETCH;
         endcase
      end
   end

   assign busOut = bus_q;
   assign regsOut = r_q;
   assign fetchStrobe = strobe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_spinc_flags;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_EXEC && op_q == OP_SPINC) |=> (r_q.cc == $past(r_q.cc));
   endproperty
   a_spinc_flags: assert property (p_spinc_flags) else $error("sp inc changed flags");

   property p_ixinc_z;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_EXEC && op_q == OP_IXINC) |=> (r_q.cc[CC_Z] == (r_q.ix == 16'h0000));
   endproperty
   a_ixinc_z: assert property (p_ixinc_z) else $error("index inc Z wrong");

   property p_jump_pc;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_OPND && opndLeft_q == 2'd1 && (op_q == OP_JMPE || op_q == OP_JMPI))
         |=> (r_q.pc == ea_q);
   endproperty
   a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

   property p_call_push;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_PUSH && !pushHigh_q)
         |-> bus_q.wr && bus_q.addr == r_q.sp
             ##1 bus_q.wr && bus_q.addr == $past(r_q.sp) - WORD_ONE
             ##1 !bus_q.wr && r_q.sp == $past(r_q.sp, 2) - RET_IDX;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push wrong");

   property p_fetch_spacing;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_FETCH && memRdata == OP_CALLE) |=> (state_q != ST_FETCH) [*8] ##1
         (state_q == ST_FETCH);
   endproperty
   a_fetch_spacing: assert property (p_fetch_spacing) else $error("call length wrong");

   property p_neg_carry;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_EXEC && aluOp == ALU_NEG && !op_q[5]) |=>
         (r_q.cc[CC_C] == ($past(aluAcc) != BYTE_ZERO));
   endproperty
   a_neg_carry: assert property (p_neg_carry) else $error("negate carry wrong");

   property p_lsr_v;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_EXEC && aluOp == ALU_LSR && !op_q[7] && !op_q[5]) |=>
         (r_q.cc[CC_V] == (r_q.cc[CC_N] ^ r_q.cc[CC_C])) && !r_q.cc[CC_N];
   endproperty
   a_lsr_v: assert property (p_lsr_v) else $error("shift V wrong");

   property p_noop_regs;
      @(posedge core_clk) disable iff (rst)
      (state_q == ST_EXEC && op_q == OP_NOOP) |=> (r_q == $past(r_q));
   endproperty
   a_noop_regs: assert property (p_noop_regs) else $error("no-op changed state");
endmodule // cxio_core

// [core/cxio_pkg.sv]
// Shared constants, opcodes and carrier types for the execution slice.
package cxio_pkg;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_INCA = 8'h4C;
   localparam logic [7:0] OP_INCB = 8'h5C;
   localparam logic [7:0] OP_INCE = 8'h7C;
   localparam logic [7:0] OP_INCI = 8'h6C;
   localparam logic [7:0] OP_SPINC = 8'h31;
   localparam logic [7:0] OP_IXINC = 8'h08;
   localparam logic [7:0] OP_JMPE = 8'h7E;
   localparam logic [7:0] OP_JMPI = 8'h6E;
   localparam logic [7:0] OP_CALLE = 8'hBD;
   localparam logic [7:0] OP_CALLI = 8'hAD;
   localparam logic [7:0] OP_LSRA = 8'h44;
   localparam logic [7:0] OP_LSRB = 8'h54;
   localparam logic [7:0] OP_LSRE = 8'h74;
   localparam logic [7:0] OP_LSRI = 8'h64;
   localparam logic [7:0] OP_NEGA = 8'h40;
   localparam logic [7:0] OP_NEGB = 8'h50;
   localparam logic [7:0] OP_NEGE = 8'h70;
   localparam logic [7:0] OP_NEGI = 8'h60;
   localparam logic [7:0] OP_NOOP = 8'h01;
   // Load and OR groups: low nibble selects the operation.
   localparam logic [3:0] NIB_LDA = 4'h6;
   localparam logic [3:0] NIB_ORA = 4'hA;
   localparam logic [3:0] NIB_LDS = 4'hE;
   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_MAXPOS = 8'h7F;
   localparam logic [7:0] BYTE_MINNEG = 8'h80;
   localparam logic [15:0] RET_EXT = 16'h0003;
   localparam logic [15:0] RET_IDX = 16'h0002;
   localparam logic [15:0] WORD_ONE = 16'h0001;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [15:0] RESET_SP = 16'h0000;
   localparam int CC_H = 5;
   localparam int CC_N = 3;
   localparam int CC_Z = 2;
   localparam int CC_V = 1;
   localparam int CC_C = 0;
   localparam logic [7:0] CC_RESET = 8'hD0;
   // Addressing mode codes, from opcode bits 5:4.
   localparam logic [1:0] AM_IMM = 2'h0;
   localparam logic [1:0] AM_DIR = 2'h1;
   localparam logic [1:0] AM_IDX = 2'h2;
   localparam logic [1:0] AM_EXT = 2'h3;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } cxio_bus_t;
   typedef struct packed {
      logic [7:0] accA;
      logic [7:0] accB;
      logic [15:0] ix;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0] cc;
   } cxio_regs_t;
   typedef enum logic [2:0] {
      ALU_INC = 3'h0,
      ALU_LSR = 3'h1,
      ALU_NEG = 3'h2,
      ALU_LD = 3'h3,
      ALU_OR = 3'h4
   } cxio_alu_t;
endpackage

// [core/cxio_alu.sv]
// Byte ALU for increment, shift, negate, load and inclusive OR.
`timescale 1ns/10ps
module cxio_alu (
   // Operation select and operands
   input wire cxio_pkg::cxio_alu_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] mem,
   input wire logic [7:0] ccIn,
   // Result
   output logic [7:0] res,
   output logic [7:0] ccOut
);
   import cxio_pkg::*;
   // ----------------------------------------------------------------
   // Result and flags
   // ----------------------------------------------------------------
   // Operand is acc for single-operand ops; the caller routes memory bytes into acc.
   always_comb begin
      res = acc;
      ccOut = ccIn;
      unique case (op)
         ALU_INC: begin
            res = acc + 8'h01;
            ccOut[CC_V] = (acc == BYTE_MAXPOS);
         end
         ALU_LSR: begin
            res = {1'b0, acc[7:1]};
            ccOut[CC_C] = acc[0];
            ccOut[CC_V] = acc[0]; // N is zero so V = N ^ C = C
         end
         ALU_NEG: begin
            res = BYTE_ZERO - acc;
            ccOut[CC_V] = (acc == BYTE_MINNEG);
            ccOut[CC_C] = (acc != BYTE_ZERO);
         end
         ALU_LD: begin
            res = mem;
            ccOut[CC_V] = 1'b0;
         end
         ALU_OR: begin
            res = acc | mem;
            ccOut[CC_V] = 1'b0;
         end
         default: res = acc;
      endcase
      ccOut[CC_N] = res[7];
      ccOut[CC_Z] = (res == BYTE_ZERO);
   end
endmodule // cxio_alu

// [core/cxio_fetch.sv]
// Operand byte collector: gathers up to two bytes in order, high first.
`timescale 1ns/10ps
module cxio_fetch (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic clear,
   input wire logic take,
   input wire logic [7:0] din,
   // Collected word
   output logic [15:0] word
);
   // Shift in so the first byte ends high after two takes.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         word <= 16'h0000;
      end else if (clear) begin
         word <= 16'h0000;
      end else if (take) begin
         word <= {word[7:0], din};
      end
   end
endmodule // cxio_fetch

// [verif/cxio_mem_model.sv]
// Behavioural memory that answers the core's bus in the same cycle.
`timescale 1ns/10ps
module cxio_mem_model (
   // Clock
   input wire logic core_clk,
   // Bus from the core
   input wire cxio_pkg::cxio_bus_t busIn,
   // Read data back to the core
   output logic [7:0] memRdata
);
   import cxio_pkg::*;
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] memArr [65536];
   logic [7:0] lastQ;
   // Zero-wait read; with no read in progress the line shows the inverse of the
   // last byte, so a stale value is never mistaken for a fresh one.
   assign memRdata = busIn.rd ? memArr[busIn.addr] : ~lastQ;
   // Store each written byte and remember the last byte read.
   always @(posedge core_clk) begin
      if (busIn.wr) begin
         memArr[busIn.addr] <= busIn.wdata;
      end
      if (busIn.rd) begin
         lastQ <= memArr[busIn.addr];
      end
   end
endmodule // cxio_mem_model

// [verif/cpu_exec_inc_to_or_tb.sv]
// Self-checking bench: reference model runs a random program beside the core.
`timescale 1ns/10ps
module cpu_exec_inc_to_or_tb;
   import cxio_pkg::*;
   // ----------------------------------------------------------------
   // Signals and reference state
   // ----------------------------------------------------------------
   logic core_clk;
   logic rst;
   logic [7:0] memRdata;
   cxio_bus_t busOut;
   cxio_regs_t regsOut;
   logic fetchStrobe;
   logic [7:0] img [65536];
   logic [7:0] rf [65536];
   logic [7:0] a, b, cc;
   logic [15:0] x, s, p, prevAddr;
   cxio_regs_t tSt[$];
   int tCy[$];
   int n_errors, samples_checked;
   logic [7:0] tbl [43] = '{8'h31, 8'h08, 8'h7E, 8'h6E, 8'hBD, 8'hAD, 8'h4C, 8'h5C, 8'h7C,
      8'h6C, 8'h44, 8'h54, 8'h74, 8'h64, 8'h40, 8'h50, 8'h70, 8'h60, 8'h01, 8'h86, 8'h96,
      8'hB6, 8'hA6, 8'hC6, 8'hD6, 8'hF6, 8'hE6, 8'h8A, 8'h9A, 8'hBA, 8'hAA, 8'hCA, 8'hDA,
      8'hFA, 8'hEA, 8'h8E, 8'h9E, 8'hBE, 8'hAE, 8'hCE, 8'hDE, 8'hFE, 8'hEE};
   cxio_core cxio_core_i (.core_clk(core_clk), .rst(rst), .memRdata(memRdata),
      .busOut(busOut), .regsOut(regsOut), .fetchStrobe(fetchStrobe));
   cxio_mem_model cxio_mem_model_i (.core_clk(core_clk), .busIn(busOut), .memRdata(memRdata));
   // Free-running clock, 10 ns period.
   always #5 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare one value and count it.
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Print the counts and the verdict, then stop.
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Execute the instruction at p in the reference model and log the state before it.
   task automatic ex();
      logic [7:0] op, v;
      logic [15:0] ea, w;
      logic [1:0] m;
      int base, len;
      op = rf[p];
      m = op[5:4];
      case (m)
         2'h0: ea = p + 16'h0001;
         2'h1: ea = {8'h00, rf[p + 16'h0001]};
         2'h2: ea = x + {8'h00, rf[p + 16'h0001]};
         default: ea = {rf[p + 16'h0001], rf[p + 16'h0002]};
      endcase
      base = (m == 2'h0) ? 2 : (m == 2'h1) ? 3 : (m == 2'h3) ? 4 : 5;
      len = (m == 2'h3) ? 3 : 2;
      tSt.push_back('{a, b, x, s, p, cc});
      if (op == OP_SPINC || op == OP_IXINC || op == OP_NOOP) begin
         len = 1;
         base = (op == OP_NOOP) ? 2 : 4;
         if (op == OP_SPINC) s = s + WORD_ONE;
         if (op == OP_IXINC) begin
            x = x + WORD_ONE;
            cc[CC_Z] = (x == 16'h0000);
         end
      end else if (op[3:0] == NIB_LDS && op[7]) begin
         w = {rf[ea], rf[ea + 16'h0001]};
         if (op[6]) x = w; else s = w;
         cc[CC_N] = w[15];
         cc[CC_Z] = (w == 16'h0000);
         cc[CC_V] = 1'b0;
         base++;
         if (m == 2'h0) len = 3;
      end else if (op == OP_JMPE || op == OP_JMPI) begin
         base--;
         p = ea - len[15:0];
      end else if (op == OP_CALLE || op == OP_CALLI) begin
         w = p + len[15:0];
         rf[s] = w[7:0];
         s = s - WORD_ONE;
         rf[s] = w[15:8];
         s = s - WORD_ONE;
         base = (m == 2'h3) ? 9 : 8;
         p = ea - len[15:0];
      end else if (op[7]) begin
         v = rf[ea] | ((op[3:0] == NIB_ORA) ? (op[6] ? b : a) : 8'h00);
         if (op[6]) b = v; else a = v;
         cc[CC_N] = v[7];
         cc[CC_Z] = (v == 8'h00);
         cc[CC_V] = 1'b0;
      end else begin
         v = (m == 2'h0) ? a : (m == 2'h1) ? b : rf[ea];
         case (op[3:0])
            4'hC: begin
               cc[CC_V] = (v == BYTE_MAXPOS);
               v = v + 8'h01;
            end
            4'h4: begin
               cc[CC_C] = v[0];
               v = v >> 1;
               cc[CC_V] = v[7] ^ cc[CC_C];
            end
            default: begin
               cc[CC_V] = (v == BYTE_MINNEG);
               v = 8'h00 - v;
               cc[CC_C] = (v != 8'h00);
            end
         endcase
         cc[CC_N] = v[7];
         cc[CC_Z] = (v == 8'h00);
         if (m == 2'h0) a = v; else if (m == 2'h1) b = v; else rf[ea] = v;
         if (m[1]) base = base + 2; else begin
            len = 1;
            base = 2;
         end
      end
      tCy.push_back(base);
      p = p + len[15:0];
   endtask
   // Place an instruction at p in both images, then run it in the model.
   task automatic emit(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2);
      {img[p], img[p + 16'h0001], img[p + 16'h0002]} = {op, o1, o2};
      {rf[p], rf[p + 16'h0001], rf[p + 16'h0002]} = {op, o1, o2};
      ex();
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   // Build the program, run the core and compare at every opcode fetch.
   initial begin
      logic [7:0] op, off, r, o1, o2;
      logic [15:0] w, g;
      logic fl;
      int k, cnt, i;
      core_clk = 1'b0;
      rst = 1'b1;
      n_errors = 0;
      samples_checked = 0;
      void'($urandom(32'h1bb8_7cf4));
      for (i = 0; i < 65536; i++) begin
         img[i] = 8'($urandom);
         rf[i] = img[i];
      end
      {a, b, x, s, p, cc} = {16'h0000, 16'h0000, RESET_SP, RESET_PC, CC_RESET};
      emit(OP_JMPE, 8'h10, 8'h00);
      // Writes land only in 0x4000 pages and the stack, clear of the code.
      for (i = 0; i < 200; i++) begin
         op = tbl[(i < 43) ? i : $urandom_range(42)];
         off = 8'($urandom);
         r = 8'($urandom);
         g = 16'($urandom_range(3));
         fl = (op == OP_JMPE || op == OP_JMPI || op == OP_CALLE || op == OP_CALLI);
         if (op == OP_CALLE || op == OP_CALLI) emit(8'h8E, 8'h81, r);
         if (op[5:4] == AM_IDX) begin
            w = fl ? (p + 16'h0005 + g - {8'h00, off}) : {8'h40, r};
            emit(8'hCE, w[15:8], w[7:0]);
            {o1, o2} = {off, r};
         end else if (fl) begin
            w = p + 16'h0003 + g;
            {o1, o2} = w;
         end else if (op[5:4] == AM_EXT) {o1, o2} = {8'h40, r};
         else {o1, o2} = {r, off};
         emit(op, o1, o2);
      end
      emit(OP_NOOP, 8'h00, 8'h00);
      emit(OP_NOOP, 8'h00, 8'h00);
      for (i = 0; i < 65536; i++) cxio_mem_model_i.memArr[i] = img[i];
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      k = 0;
      cnt = 0;
      prevAddr = 16'h0000;
      for (i = 0; i < 20000 && k < tSt.size(); i++) begin
         @(negedge core_clk);
         cnt++;
         if (fetchStrobe === 1'b1) begin
            chk("pc", prevAddr, tSt[k].pc);
            chk("accA", {8'h00, regsOut.accA}, {8'h00, tSt[k].accA});
            chk("accB", {8'h00, regsOut.accB}, {8'h00, tSt[k].accB});
            chk("ix", regsOut.ix, tSt[k].ix);
            chk("sp", regsOut.sp, tSt[k].sp);
            chk("cc", {8'h00, regsOut.cc}, {8'h00, tSt[k].cc});
            if (k > 0) chk("cycles", 16'(cnt), 16'(tCy[k - 1]));
            k++;
            cnt = 0;
         end
         prevAddr = busOut.addr;
      end
      if (k < tSt.size()) n_errors++;
      for (i = 16'h4000; i < 16'h4200; i++) begin
         chk("data", {8'h00, cxio_mem_model_i.memArr[i]}, {8'h00, rf[i]});
         chk("stack", {8'h00, cxio_mem_model_i.memArr[i + 16'h4000]}, {8'h00, rf[i + 16'h4000]});
      end
      end_sim();
   end
endmodule // cpu_exec_inc_to_or_tb
